// ---- dv/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [3:0]        pins = 4'h0;
	logic [7:0]        ctrl_wr_data = 8'h00;
	logic [2:0]        ctrl_rd_sel = 3'h0;
	logic [5:0]        ctrl_wr_en = 6'h00, sync_select_register = 6'h00;
	logic [5:0]        counter_enable = 6'h3f, phase_mode = 6'h00;
	logic [5:0]        phase_count_up = 6'h00, phase_count_down = 6'h00;
	logic [5:0]        buffer_c_en = 6'h00, buffer_d_en = 6'h00;
	logic [5:0]        match_a = 6'h00, match_b = 6'h00, match_c = 6'h00, match_d = 6'h00;
	logic [7:0]        ctrl_rd_data;
	logic [5:0][15:0]  timer_count_value;
	logic [5:0]        overflow, underflow, count_tick, counter_clear;
	int                fails = 0;
	int                samples_checked = 0;

	timer_clock_clear_select timer_clock_clear_select_i (
		.sys_clk, .rst_n, .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]),
		.ext_clock_pin_c(pins[2]), .ext_clock_pin_d(pins[3]), .ctrl_wr_en, .ctrl_wr_data,
		.ctrl_rd_sel, .ctrl_rd_data, .sync_select_register, .counter_enable, .phase_mode,
		.phase_count_up, .phase_count_down, .buffer_c_en, .buffer_d_en, .match_a,
		.match_b, .match_c, .match_d, .timer_count_value, .overflow, .underflow,
		.count_tick, .counter_clear
	);

	always #12.5 sys_clk = ~sys_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] ch, input logic [7:0] d);
		@(negedge sys_clk);
		ctrl_wr_en = ch;
		ctrl_wr_data = d;
		@(negedge sys_clk);
		ctrl_wr_en = 6'h00;
	endtask

	// One-cycle compare pulse of kind m (0 a .. 3 d) on the given channels
	task automatic hit(input int m, input logic [5:0] ch);
		{match_d, match_c, match_b, match_a} = 24'(ch) << (6 * m);
		@(negedge sys_clk);
		{match_d, match_c, match_b, match_a} = 24'h000000;
	endtask

	// Second interval between ticks, so the switch-over gap is skipped
	task automatic per(input int c, input int exp);
		int n = 0;
		@(negedge sys_clk);
		while (count_tick[c] !== 1'b1 && n < 9000) begin
			@(negedge sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (count_tick[c] !== 1'b1 && n < 9000);
		chk(16'(n), 16'(exp));
	endtask

	task automatic t_rd();
		wr(6'h3f, 8'hff);
		for (int c = 0; c < 8; c++) begin
			ctrl_rd_sel = c[2:0];
			@(negedge sys_clk);
			chk(ctrl_rd_data, c > 5 ? 8'h00 : (c % 3 == 0) ? 8'hff : 8'h7f);
		end
		wr(6'h3f, 8'h00);
	endtask

	task automatic t_psc();
		int ch[14] = '{0, 0, 0, 0, 3, 3, 3, 1, 2, 4, 5, 0, 0, 0};
		logic [7:0] w[14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h06,
			8'h07, 8'h06, 8'h06, 8'h19, 8'h09, 8'h18};
		int p[14] = '{1, 4, 16, 64, 1024, 256, 4096, 256, 1024, 1024, 256, 2, 4, 1};
		for (int i = 0; i < 14; i++) begin
			wr(6'h01 << ch[i], w[i]);
			per(ch[i], p[i]);
		end
	endtask

	task automatic t_pin();
		int ch[15] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 3, 4, 4, 5, 5, 5};
		logic [2:0] c[15] = '{4, 5, 6, 7, 4, 5, 4, 5, 6, 4, 4, 5, 4, 5, 7};
		int pn[15] = '{0, 1, 2, 3, 0, 1, 0, 1, 2, 0, 0, 2, 0, 2, 3};
		logic [15:0] v;
		for (int i = 0; i < 15; i++) begin
			wr(6'h01 << ch[i], {5'h00, c[i]});
			v = timer_count_value[ch[i]];
			pins[pn[i]] = 1'b1;
			repeat (6) @(negedge sys_clk);
			pins[pn[i]] = 1'b0;
			repeat (6) @(negedge sys_clk);
			chk(timer_count_value[ch[i]], v + 16'h0001);
		end
	endtask

	// Phase pulses on 2 and 5 wrap them both ways; 1 and 4 follow by cascade
	task automatic t_casc();
		logic [15:0] v1, v4;
		phase_mode = 6'h24;
		wr(6'h24, 8'h20);
		wr(6'h12, 8'h07);
		hit(0, 6'h24);
		v1 = timer_count_value[1];
		v4 = timer_count_value[4];
		repeat (3) @(negedge sys_clk);
		chk(timer_count_value[2], 16'h0000);
		phase_count_down = 6'h24;
		@(negedge sys_clk);
		phase_count_down = 6'h00;
		repeat (3) @(negedge sys_clk);
		chk(timer_count_value[5], 16'hffff);
		phase_count_up = 6'h24;
		@(negedge sys_clk);
		phase_count_up = 6'h00;
		repeat (3) @(negedge sys_clk);
		chk(timer_count_value[1], v1 + 16'h0002);
		chk(timer_count_value[4], v4 + 16'h0002);
		phase_mode = 6'h00;
	endtask

	task automatic t_clr();
		int ch[12] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 4};
		logic [7:0] w[12] = '{8'h20, 8'h40, 8'ha0, 8'hc0, 8'h80, 8'ha0, 8'hc0, 8'h20,
			8'h40, 8'h40, 8'h00, 8'hc0};
		int m[12] = '{0, 1, 2, 3, 0, 2, 3, 0, 1, 0, 0, 1};
		logic [1:0] bf[12] = '{0, 0, 0, 0, 0, 1, 2, 0, 0, 0, 0, 0};
		logic e[12] = '{1, 1, 1, 1, 0, 0, 0, 1, 1, 0, 0, 1};
		for (int i = 0; i < 12; i++) begin
			{buffer_d_en[0], buffer_c_en[0]} = bf[i];
			wr(6'h01 << ch[i], w[i]);
			hit(m[i], 6'h01 << ch[i]);
			chk(counter_clear[ch[i]], e[i]);
		end
		{buffer_d_en[0], buffer_c_en[0]} = 2'h0;
	endtask

	// Channel 2 selects sync clear but is left out of the sync group
	task automatic t_sync();
		sync_select_register = 6'h03;
		wr(6'h01, 8'h20);
		wr(6'h06, 8'h60);
		hit(0, 6'h01);
		chk(counter_clear[2:0], 16'h0003);
	endtask

	// Pin A counted on falling edges only, then a stopped counter holds
	task automatic t_hold();
		logic [15:0] v;
		wr(6'h01, 8'h0c);
		v = timer_count_value[0];
		pins[0] = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk(timer_count_value[0], v);
		pins[0] = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(timer_count_value[0], v + 16'h0001);
		wr(6'h01, 8'h00);
		counter_enable = 6'h3e;
		v = timer_count_value[0];
		repeat (4) @(negedge sys_clk);
		chk(timer_count_value[0], v);
		chk(count_tick[0], 1'b0);
		counter_enable = 6'h3f;
	endtask

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		t_rd();
		t_psc();
		t_pin();
		t_casc();
		t_clr();
		t_sync();
		t_hold();
		summarize();
	end

	initial begin
		#2ms;
		fails++;
		summarize();
	end
endmodule

// ---- dv/timer_clock_clear_select_checker.sv ----
module timer_clock_clear_select_checker
	import timer_clk_pkg::*;
(
	input wire logic                          sys_clk,
	input wire logic                          rst_n,
	input wire logic [NUM_CH-1:0]             ctrl_wr_en,
	input wire logic [7:0]                    ctrl_wr_data,
	input wire logic [2:0]                    ctrl_rd_sel,
	input wire logic [7:0]                    ctrl_rd_data,
	input wire logic [NUM_CH-1:0]             counter_enable,
	input wire logic [NUM_CH-1:0]             buffer_c_en,
	input wire logic [NUM_CH-1:0]             match_a,
	input wire logic [NUM_CH-1:0][CNT_W-1:0]  timer_count_value,
	input wire logic [NUM_CH-1:0]             overflow,
	input wire logic [NUM_CH-1:0]             underflow,
	input wire logic [NUM_CH-1:0]             count_tick,
	input wire logic [NUM_CH-1:0]             counter_clear
);
	// Shadow of channel 0 word, since the checker sees no internal state
	logic [7:0] shadow;
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			shadow <= CTRL_RESET;
		else if (ctrl_wr_en[0])
			shadow <= ctrl_wr_data;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_tick_adds_one: assert property (
		count_tick[0] |-> timer_count_value[0] == $past(timer_count_value[0]) + 16'h0001)
		else $error("tick without increment");
	a_clear_zero: assert property (
		counter_clear[0] |-> timer_count_value[0] == COUNT_RESET && !count_tick[0])
		else $error("clear left count nonzero");
	a_match_a_clears: assert property (
		match_a[0] && shadow[7:5] == 3'h1 |=> counter_clear[0])
		else $error("match a did not clear");
	a_none_no_clear: assert property (
		counter_clear[0] |-> $past(shadow[6:5]) != CLR_NONE)
		else $error("clear with clearing off");
	a_buf_c_blocks: assert property (
		$past(rst_n && shadow[7:5] == 3'h5 && buffer_c_en[0]) |-> !counter_clear[0])
		else $error("buffered c cleared counter");
	a_rd_reserved: assert property (
		$past(ctrl_rd_sel) inside {3'h1, 3'h2, 3'h4, 3'h5} |-> !ctrl_rd_data[7])
		else $error("reserved bit read as one");
	a_wrap_over: assert property (
		overflow[2] |-> timer_count_value[2] == COUNT_RESET
		&& $past(timer_count_value[2]) == COUNT_MAX)
		else $error("overflow without wrap");
	a_wrap_under: assert property (
		underflow[2] |-> timer_count_value[2] == COUNT_MAX
		&& $past(timer_count_value[2]) == COUNT_RESET)
		else $error("underflow without wrap");
	a_phi1_steady: assert property (
		$past(rst_n && counter_enable[0] && shadow[2:0] == 3'h0 && shadow[6:5] == CLR_NONE)
		|-> count_tick[0])
		else $error("undivided clock missed a tick");
	c_clear: cover property (counter_clear[0]);
	c_over: cover property (overflow[2]);
	c_under: cover property (underflow[2]);
endmodule

bind timer_clock_clear_select timer_clock_clear_select_checker timer_clock_clear_select_checker_i (
	.sys_clk, .rst_n, .ctrl_wr_en, .ctrl_wr_data, .ctrl_rd_sel, .ctrl_rd_data,
	.counter_enable, .buffer_c_en, .match_a, .timer_count_value, .overflow,
	.underflow, .count_tick, .counter_clear
);

// ---- logic/tick_source_gen.sv ----
module tick_source_gen
	import timer_clk_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic [3:0]          ext_pins,
	output logic      [NUM_TAPS-1:0] div_rise,
	output logic      [NUM_TAPS-1:0] div_fall,
	output logic      [3:0]          pin_rise,
	output logic      [3:0]          pin_fall
);

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [DIV_W-1:0] div_prev;
		logic [3:0]       sync1;
		logic [3:0]       sync2;
		logic [3:0]       sync3;
	} gen_state_t;

	gen_state_t s;
	gen_state_t next_s;

	function automatic logic [NUM_TAPS-1:0] taps(input logic [DIV_W-1:0] d);
		taps = {d[TAP_DIV4096], d[TAP_DIV1024], d[TAP_DIV256],
			d[TAP_DIV64], d[TAP_DIV16], d[TAP_DIV4]};
	endfunction

	always_comb begin
		next_s          = s;
		next_s.div      = s.div + 1'b1;
		next_s.div_prev = s.div;
		// Pins are asynchronous: two flops, then a third for edge history
		next_s.sync1    = ext_pins;
		next_s.sync2    = s.sync1;
		next_s.sync3    = s.sync2;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Divided clocks are square waves; their edges become tick pulses
	assign div_rise = taps(s.div) & ~taps(s.div_prev);
	assign div_fall = ~taps(s.div) & taps(s.div_prev);
	assign pin_rise = s.sync2 & ~s.sync3;
	assign pin_fall = ~s.sync2 & s.sync3;

endmodule

// ---- logic/timer_clk_pkg.sv ----
package timer_clk_pkg;

	localparam int          NUM_CH       = 6;
	localparam int          CNT_W        = 16;
	localparam int          DIV_W        = 12;
	localparam int          NUM_TAPS     = 6;

	// Control word layout: clear field, edge field, prescale field
	localparam int          CLR_MSB      = 7;
	localparam int          CLR_LSB      = 5;
	localparam int          EDGE_MSB     = 4;
	localparam int          EDGE_LSB     = 3;
	localparam int          PSC_MSB      = 2;
	localparam int          PSC_LSB      = 0;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_MAX    = 16'hffff;

	// Divider tap bit for each divided clock (period = 2 << bit)
	localparam int          TAP_DIV4     = 1;
	localparam int          TAP_DIV16    = 3;
	localparam int          TAP_DIV64    = 5;
	localparam int          TAP_DIV256   = 7;
	localparam int          TAP_DIV1024  = 9;
	localparam int          TAP_DIV4096  = 11;
	// Index of each tap in the divider pulse vectors
	localparam int          IDX_DIV4     = 0;
	localparam int          IDX_DIV16    = 1;
	localparam int          IDX_DIV64    = 2;
	localparam int          IDX_DIV256   = 3;
	localparam int          IDX_DIV1024  = 4;
	localparam int          IDX_DIV4096  = 5;

	// Clear codes, low two bits shared by all channels
	localparam logic [1:0]  CLR_NONE     = 2'h0;
	localparam logic [1:0]  CLR_FIRST    = 2'h1;
	localparam logic [1:0]  CLR_SECOND   = 2'h2;
	localparam logic [1:0]  CLR_SYNC     = 2'h3;

	typedef enum logic [11:0] {
		SRC_PHI1    = 12'h001,
		SRC_DIV4    = 12'h002,
		SRC_DIV16   = 12'h004,
		SRC_DIV64   = 12'h008,
		SRC_DIV256  = 12'h010,
		SRC_DIV1024 = 12'h020,
		SRC_DIV4096 = 12'h040,
		SRC_PIN_A   = 12'h080,
		SRC_PIN_B   = 12'h100,
		SRC_PIN_C   = 12'h200,
		SRC_PIN_D   = 12'h400,
		SRC_CASCADE = 12'h800
	} count_src_t;

endpackage

// ---- logic/timer_clock_clear_select.sv ----
// Behaviour
// - Ch1,2,4,5 two-bit clear code picks source
// - Sync clear only on sync-selected channels
// - Buffered C/D registers never clear counter
// - Ch1,2,4,5 clear top bit reads zero
// - Codes 0-3 count phi/1,/4,/16,/64
// - Ch0 codes 4-7 count pins A-D
// - Ch1: pins A,B, phi/256, ch2 cascade
// - Phase mode overrides prescale on 1,2,4,5
// - Ch2: pins A,B,C, phi/1024
// - Ch3: pin A, phi/1024,/256,/4096
// - Ch4: pins A,C, phi/1024, ch5 cascade
// - Ch5: pins A,C, phi/256, pin D
// - Edge field: rise, fall, both
// - Edge ignored for phi/1 and cascade
// - Ch0,3 three-bit clear adds C, D
module timer_clock_clear_select
	import timer_clk_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ext_clock_pin_a,
	input  wire logic                        ext_clock_pin_b,
	input  wire logic                        ext_clock_pin_c,
	input  wire logic                        ext_clock_pin_d,
	input  wire logic [NUM_CH-1:0]           ctrl_wr_en,
	input  wire logic [7:0]                  ctrl_wr_data,
	input  wire logic [2:0]                  ctrl_rd_sel,
	output logic      [7:0]                  ctrl_rd_data,
	input  wire logic [NUM_CH-1:0]           sync_select_register,
	input  wire logic [NUM_CH-1:0]           counter_enable,
	input  wire logic [NUM_CH-1:0]           phase_mode,
	input  wire logic [NUM_CH-1:0]           phase_count_up,
	input  wire logic [NUM_CH-1:0]           phase_count_down,
	input  wire logic [NUM_CH-1:0]           buffer_c_en,
	input  wire logic [NUM_CH-1:0]           buffer_d_en,
	input  wire logic [NUM_CH-1:0]           match_a,
	input  wire logic [NUM_CH-1:0]           match_b,
	input  wire logic [NUM_CH-1:0]           match_c,
	input  wire logic [NUM_CH-1:0]           match_d,
	output logic      [NUM_CH-1:0][CNT_W-1:0] timer_count_value,
	output logic      [NUM_CH-1:0]           overflow,
	output logic      [NUM_CH-1:0]           underflow,
	output logic      [NUM_CH-1:0]           count_tick,
	output logic      [NUM_CH-1:0]           counter_clear
);

	typedef struct packed {
		logic [NUM_CH-1:0][7:0]       ctrl;
		logic [NUM_CH-1:0][CNT_W-1:0] count;
		logic [NUM_CH-1:0]            ovf;
		logic [NUM_CH-1:0]            unf;
		logic [NUM_CH-1:0]            tick;
		logic [NUM_CH-1:0]            clr;
		logic [7:0]                   rd_data;
	} main_state_t;

	main_state_t s;
	main_state_t next_s;

	logic [NUM_TAPS-1:0] div_rise;
	logic [NUM_TAPS-1:0] div_fall;
	logic [3:0]          pin_rise;
	logic [3:0]          pin_fall;

	tick_source_gen u_ticks (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.ext_pins ({ext_clock_pin_d, ext_clock_pin_c,
			ext_clock_pin_b, ext_clock_pin_a}),
		.div_rise (div_rise),
		.div_fall (div_fall),
		.pin_rise (pin_rise),
		.pin_fall (pin_fall)
	);

	// Channels 0 and 3 carry registers C and D and the wide clear field
	function automatic logic wide_clear(input int ch);
		wide_clear = (ch == 0) || (ch == 3);
	endfunction

	function automatic logic edge_pulse(input logic [1:0] edg,
		input logic rise, input logic fall);
		if (edg[1]) begin
			edge_pulse = rise | fall;
		end else if (edg[0]) begin
			edge_pulse = fall;
		end else begin
			edge_pulse = rise;
		end
	endfunction

	function automatic count_src_t source_of(input int ch,
		input logic [2:0] psc);
		source_of = SRC_PHI1;
		if (!psc[2]) begin
			case (psc[1:0])
				2'h0: source_of = SRC_PHI1;
				2'h1: source_of = SRC_DIV4;
				2'h2: source_of = SRC_DIV16;
				default: source_of = SRC_DIV64;
			endcase
		end else begin
			case (ch)
				0: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_PIN_B;
						2'h2: source_of = SRC_PIN_C;
						default: source_of = SRC_PIN_D;
					endcase
				end
				1: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_PIN_B;
						2'h2: source_of = SRC_DIV256;
						default: source_of = SRC_CASCADE;
					endcase
				end
				2: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_PIN_B;
						2'h2: source_of = SRC_PIN_C;
						default: source_of = SRC_DIV1024;
					endcase
				end
				3: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_DIV1024;
						2'h2: source_of = SRC_DIV256;
						default: source_of = SRC_DIV4096;
					endcase
				end
				4: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_PIN_C;
						2'h2: source_of = SRC_DIV1024;
						default: source_of = SRC_CASCADE;
					endcase
				end
				default: begin
					case (psc[1:0])
						2'h0: source_of = SRC_PIN_A;
						2'h1: source_of = SRC_PIN_C;
						2'h2: source_of = SRC_DIV256;
						default: source_of = SRC_PIN_D;
					endcase
				end
			endcase
		end
	endfunction

	function automatic logic div_tick(input logic [1:0] edg, input int idx,
		input logic [NUM_TAPS-1:0] r, input logic [NUM_TAPS-1:0] f);
		div_tick = edge_pulse(edg, r[idx], f[idx]);
	endfunction

	// One count pulse from the chosen source this cycle
	function automatic logic source_tick(input count_src_t src,
		input logic [1:0] edg, input logic cascade,
		input logic [NUM_TAPS-1:0] dr, input logic [NUM_TAPS-1:0] df,
		input logic [3:0] pr, input logic [3:0] pf);
		case (src)
			SRC_PHI1:    source_tick = 1'b1;
			SRC_DIV4:    source_tick = div_tick(edg, IDX_DIV4, dr, df);
			SRC_DIV16:   source_tick = div_tick(edg, IDX_DIV16, dr, df);
			SRC_DIV64:   source_tick = div_tick(edg, IDX_DIV64, dr, df);
			SRC_DIV256:  source_tick = div_tick(edg, IDX_DIV256, dr, df);
			SRC_DIV1024: source_tick = div_tick(edg, IDX_DIV1024, dr, df);
			SRC_DIV4096: source_tick = div_tick(edg, IDX_DIV4096, dr, df);
			SRC_PIN_A:   source_tick = edge_pulse(edg, pr[0], pf[0]);
			SRC_PIN_B:   source_tick = edge_pulse(edg, pr[1], pf[1]);
			SRC_PIN_C:   source_tick = edge_pulse(edg, pr[2], pf[2]);
			SRC_PIN_D:   source_tick = edge_pulse(edg, pr[3], pf[3]);
			SRC_CASCADE: source_tick = cascade;
			default:     source_tick = 1'b0;
		endcase
	endfunction

	// Clear caused by this channel's own compare/capture sources
	function automatic logic own_clear(input int ch, input logic [2:0] code,
		input logic ma, input logic mb, input logic mc, input logic md,
		input logic bc, input logic bd);
		own_clear = 1'b0;
		if (wide_clear(ch) && code[2]) begin
			case (code[1:0])
				CLR_FIRST:  own_clear = mc & ~bc;
				CLR_SECOND: own_clear = md & ~bd;
				default:    own_clear = 1'b0;
			endcase
		end else begin
			case (code[1:0])
				CLR_FIRST:  own_clear = ma;
				CLR_SECOND: own_clear = mb;
				default:    own_clear = 1'b0;
			endcase
		end
	endfunction

	// Neighbour feeding each channel's cascade input
	function automatic int cascade_from(input int ch);
		cascade_from = (ch == 1) ? 2 : 5;
	endfunction

	logic [NUM_CH-1:0] self_clr;
	logic [NUM_CH-1:0] sync_req;
	logic              group_clr;

	always_comb begin
		self_clr = '0;
		sync_req = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			self_clr[c] = own_clear(c, s.ctrl[c][CLR_MSB:CLR_LSB],
				match_a[c], match_b[c], match_c[c], match_d[c],
				buffer_c_en[c], buffer_d_en[c]);
			sync_req[c] = (s.ctrl[c][CLR_LSB+1:CLR_LSB] == CLR_SYNC)
				&& sync_select_register[c];
		end
	end

	// A synced channel with its own clear source drives the group
	assign group_clr = |(self_clr & sync_select_register);

	always_comb begin
		logic [2:0]  psc;
		logic [1:0]  edg;
		logic        casc;
		logic        src_tk;
		logic        phase;
		logic        up;
		logic        down;
		logic        clr;
		count_src_t  src;
		psc     = '0;
		edg     = '0;
		casc    = 1'b0;
		src_tk  = 1'b0;
		phase   = 1'b0;
		up      = 1'b0;
		down    = 1'b0;
		clr     = 1'b0;
		src     = SRC_PHI1;
		next_s  = s;
		for (int c = 0; c < NUM_CH; c++) begin
			if (ctrl_wr_en[c]) begin
				next_s.ctrl[c] = ctrl_wr_data;
				if (!wide_clear(c)) begin
					next_s.ctrl[c][CLR_MSB] = 1'b0;
				end
			end
			psc = s.ctrl[c][PSC_MSB:PSC_LSB];
			edg = s.ctrl[c][EDGE_MSB:EDGE_LSB];
			src = source_of(c, psc);
			// Cascade uses the neighbour's registered wrap, one cycle late
			casc = (c == 1 || c == 4) &&
				(s.ovf[cascade_from(c)] || s.unf[cascade_from(c)]);
			src_tk = source_tick(src, edg, casc, div_rise, div_fall,
				pin_rise, pin_fall);
			// Phase mode does not exist on channels 0 and 3
			phase = phase_mode[c] && !wide_clear(c);
			if (phase) begin
				up   = phase_count_up[c];
				down = phase_count_down[c] & ~phase_count_up[c];
			end else begin
				up   = src_tk;
				down = 1'b0;
			end
			up   = up & counter_enable[c];
			down = down & counter_enable[c];
			clr  = self_clr[c] | (sync_req[c] & group_clr);
			// Clear wins over a count in the same cycle
			next_s.clr[c]  = clr;
			next_s.tick[c] = !clr && (up || down);
			next_s.ovf[c]  = !clr && up && (s.count[c] == COUNT_MAX);
			next_s.unf[c]  = !clr && down && (s.count[c] == COUNT_RESET);
			if (clr) begin
				next_s.count[c] = COUNT_RESET;
			end else if (up) begin
				next_s.count[c] = s.count[c] + 1'b1;
			end else if (down) begin
				next_s.count[c] = s.count[c] - 1'b1;
			end
		end
		next_s.rd_data = 8'h00;
		if (ctrl_rd_sel < 3'(NUM_CH)) begin
			next_s.rd_data = s.ctrl[ctrl_rd_sel];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int c = 0; c < NUM_CH; c++) begin
				s.ctrl[c]  <= CTRL_RESET;
				s.count[c] <= COUNT_RESET;
			end
			s.ovf     <= '0;
			s.unf     <= '0;
			s.tick    <= '0;
			s.clr     <= '0;
			s.rd_data <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	assign timer_count_value = s.count;
	assign overflow          = s.ovf;
	assign underflow         = s.unf;
	assign count_tick        = s.tick;
	assign counter_clear     = s.clr;
	assign ctrl_rd_data      = s.rd_data;

endmodule
